// *** src/dmx_pkg.sv ***
// Function
// - right filter-1 mix select field is bits 6:0, resets to 0x4.
// - select bits 0..6 map filter1 L/R, filter2 L/R, tone, serial in1 L/R.
// - a set select bit adds that source to the sum; several allowed.
// - select bit 7 is reserved and never affects mixing.
// - serial output 2 left has its own select field, same map, reset 0x4.
// - gain fields are 5 bits; code 0 is -42 dB, 1.5 dB per step.
// - code 0x1C is 0 dB and code 0x1F is +4.5 dB.
// - filter1 left path to right filter-1 mix has gain bits 4:0, reset 0x1C.
// - filter1 right path to right filter-1 mix has own gain, reset unity.
// - filter2 left path to right filter-1 mix has own gain, reset unity.
// - filter2 right path to right filter-1 mix has own gain, reset unity.
// - tone path to right filter-1 mix has own gain, reset unity.
// - serial in1 left path to right filter-1 mix has own gain, reset unity.
// - serial in1 right path to right filter-1 mix has own gain, reset unity.
// - serial in1 right path to left filter-1 mix has own gain, reset unity.
package dmx_pkg;
   localparam int SAMPLE_W = 24;
   localparam int GAIN_W = 5;
   localparam int COEF_W = 16;
   localparam int COEF_FRAC = 14;
   localparam int PROD_W = SAMPLE_W + COEF_W + 1 - COEF_FRAC;
   localparam int ACC_W = PROD_W + 3;
   localparam int NSRC = 7;
   localparam int FIFO_DEPTH = 32;
   localparam int ADDR_LSB = 2;
   localparam int ADDR_IDX_W = 8;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_L_D1R_GAIN = 8'h73;
   localparam logic [7:0] IDX_R_SEL = 8'h74;
   localparam logic [7:0] IDX_R_F1L_GAIN = 8'h75;
   localparam logic [7:0] IDX_R_F1R_GAIN = 8'h76;
   localparam logic [7:0] IDX_R_F2L_GAIN = 8'h77;
   localparam logic [7:0] IDX_R_F2R_GAIN = 8'h78;
   localparam logic [7:0] IDX_R_TONE_GAIN = 8'h79;
   localparam logic [7:0] IDX_R_D1L_GAIN = 8'h7A;
   localparam logic [7:0] IDX_R_D1R_GAIN = 8'h7B;
   localparam logic [7:0] IDX_O2L_SEL = 8'h7C;
   localparam logic [7:0] IDX_STATUS = 8'h40;
   localparam int STAT_LEVEL_LSB = 0;
   localparam int STAT_SAT_BIT = 8;
   localparam logic [6:0] RST_SEL = 7'h04;
   localparam logic [4:0] RST_GAIN = 5'h1C;
   localparam logic [4:0] GAIN_UNITY = 5'h1C;
   // source positions in select fields and sample vectors
   localparam int SRC_F1L = 0;
   localparam int SRC_F1R = 1;
   localparam int SRC_F2L = 2;
   localparam int SRC_F2R = 3;
   localparam int SRC_TONE = 4;
   localparam int SRC_D1L = 5;
   localparam int SRC_D1R = 6;
   // linear gain, 2.14 fixed point, one entry per 1.5 dB step from -42 dB
   localparam logic [15:0] GAIN_COEF [32] = '{
      16'h0082, 16'h009B, 16'h00B8, 16'h00DA, 16'h0104, 16'h0135, 16'h016F, 16'h01B4,
      16'h0206, 16'h0268, 16'h02DC, 16'h0366, 16'h040A, 16'h04CD, 16'h05B4, 16'h06C7,
      16'h080F, 16'h0993, 16'h0B62, 16'h0D87, 16'h1013, 16'h131B, 16'h16B5, 16'h1AFD,
      16'h2013, 16'h261F, 16'h2D4F, 16'h35D9, 16'h4000, 16'h4C10, 16'h5A67, 16'h6B71};

   function automatic logic signed [PROD_W-1:0] scale_sample(
         input logic signed [SAMPLE_W-1:0] s, input logic [GAIN_W-1:0] code);
      logic signed [SAMPLE_W+COEF_W:0] p;
      p = s * $signed({1'b0, GAIN_COEF[code]});
      return p[SAMPLE_W+COEF_W:COEF_FRAC];
   endfunction

   function automatic logic signed [ACC_W-1:0] mix_sum(input logic [NSRC-1:0] sel,
         input logic [NSRC-1:0][GAIN_W-1:0] g, input logic [NSRC-1:0][SAMPLE_W-1:0] smp);
      logic signed [ACC_W-1:0] acc;
      acc = '0;
      for (int i = 0; i < NSRC; i++) begin
         if (sel[i]) begin
            acc = acc + ACC_W'(scale_sample($signed(smp[i]), g[i]));
         end
      end
      return acc;
   endfunction

   function automatic logic is_sat(input logic signed [ACC_W-1:0] a);
      // the cast widens its operand first, so a minus there would flip the lower limit positive
      return (a > ACC_W'(24'sh7FFFFF)) || (a < ACC_W'(24'sh800000));
   endfunction

   function automatic logic [SAMPLE_W-1:0] sat_sample(input logic signed [ACC_W-1:0] a);
      if (a > ACC_W'(24'sh7FFFFF)) begin
         return 24'h7FFFFF;
      end else if (a < ACC_W'(24'sh800000)) begin
         return 24'h800000;
      end else begin
         return a[SAMPLE_W-1:0];
      end
   endfunction
endpackage

// *** src/dmx_mixer.sv ***
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module dmx_fifo #(
   parameter int W = 72,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   // fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [CW-1:0] count;
   } dmx_fifo_state_t;

   dmx_fifo_state_t st_r;
   dmx_fifo_state_t st_nxt;
   logic push;
   logic pop;

   assign in_ready = st_r.count != CW'(DEPTH);
   assign out_valid = st_r.count != '0;
   assign out_data = st_r.mem[st_r.rd_ptr];
   assign level = st_r.count;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wr_ptr] = in_data;
         st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
      end
      if (pop) begin
         st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.count = st_r.count + 1'b1;
      end else if (pop && !push) begin
         st_nxt.count = st_r.count - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // dmx_fifo

module dmx_mixer
   import dmx_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // source samples, one frame per src_valid and src_ready
   input wire logic src_valid,
   output logic src_ready,
   input wire logic [SAMPLE_W-1:0] input_filter1_left,
   input wire logic [SAMPLE_W-1:0] input_filter1_right,
   input wire logic [SAMPLE_W-1:0] input_filter2_left,
   input wire logic [SAMPLE_W-1:0] input_filter2_right,
   input wire logic [SAMPLE_W-1:0] tone_sample,
   input wire logic [SAMPLE_W-1:0] serial_in1_left,
   input wire logic [SAMPLE_W-1:0] serial_in1_right,
   // mixed samples out through the fifo
   output logic mix_valid,
   input wire logic mix_ready,
   output logic [SAMPLE_W-1:0] filter1_right_mix_out,
   output logic [SAMPLE_W-1:0] filt1_left_dai1r_term,
   output logic [SAMPLE_W-1:0] serial_out2_left_stream
);
   localparam int OUT_W = 3 * SAMPLE_W;
   localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

   typedef struct packed {
      logic [NSRC-1:0] r_sel;
      logic [NSRC-1:0] o2_sel;
      logic [NSRC-1:0][GAIN_W-1:0] r_gain;
      logic [GAIN_W-1:0] l_gain;
      logic wr_pend;
      logic [ADDR_IDX_W-1:0] wr_idx;
      logic [31:0] rdata;
      logic sat_seen;
   } dmx_state_t;

   localparam dmx_state_t ST_RESET = '{
      r_sel: RST_SEL,
      o2_sel: RST_SEL,
      r_gain: {NSRC{RST_GAIN}},
      l_gain: RST_GAIN,
      wr_pend: 1'b0,
      wr_idx: '0,
      rdata: '0,
      sat_seen: 1'b0};

   dmx_state_t st_r;
   dmx_state_t st_nxt;
   logic [NSRC-1:0][SAMPLE_W-1:0] smp;
   logic [OUT_W-1:0] fifo_in;
   logic [OUT_W-1:0] fifo_out;
   logic [LVL_W-1:0] fifo_level;
   logic fifo_in_ready;
   logic take;
   logic addr_ok;
   logic [ADDR_IDX_W-1:0] a_idx;
   logic signed [ACC_W-1:0] r_acc;
   logic signed [ACC_W-1:0] l_acc;
   logic signed [ACC_W-1:0] o2_acc;
   logic [SAMPLE_W-1:0] r_mix;
   logic [SAMPLE_W-1:0] l_mix;
   logic [SAMPLE_W-1:0] o2_mix;
   logic sat_now;

   // source order fixes the meaning of each select bit
   always_comb begin
      smp[SRC_F1L] = input_filter1_left;
      smp[SRC_F1R] = input_filter1_right;
      smp[SRC_F2L] = input_filter2_left;
      smp[SRC_F2R] = input_filter2_right;
      smp[SRC_TONE] = tone_sample;
      smp[SRC_D1L] = serial_in1_left;
      smp[SRC_D1R] = serial_in1_right;
   end

   // whole frame mixed in one cycle from one register state, so a
   // write can never split a sample between old and new settings
   assign r_acc = mix_sum(st_r.r_sel, st_r.r_gain, smp);
   // serial output 2 has no gains in this block; paths run at unity
   assign o2_acc = mix_sum(st_r.o2_sel, {NSRC{GAIN_UNITY}}, smp);
   // only this one path of the left filter-1 mix lives here
   assign l_acc = ACC_W'(scale_sample($signed(serial_in1_right), st_r.l_gain));
   assign r_mix = sat_sample(r_acc);
   assign l_mix = sat_sample(l_acc);
   assign o2_mix = sat_sample(o2_acc);
   assign sat_now = take && (is_sat(r_acc) || is_sat(o2_acc) || is_sat(l_acc));

   assign take = src_valid && fifo_in_ready;
   assign src_ready = fifo_in_ready;
   assign fifo_in = {r_mix, l_mix, o2_mix};

   assign addr_ok = hsel && hready && htrans[1];
   assign a_idx = haddr[ADDR_LSB+ADDR_IDX_W-1:ADDR_LSB];

   always_comb begin
      st_nxt = st_r;
      // data phase of a write
      if (st_r.wr_pend) begin
         if (st_r.wr_idx == IDX_R_SEL) begin
            st_nxt.r_sel = hwdata[NSRC-1:0];
         end else if (st_r.wr_idx == IDX_O2L_SEL) begin
            st_nxt.o2_sel = hwdata[NSRC-1:0];
         end else if (st_r.wr_idx == IDX_L_D1R_GAIN) begin
            st_nxt.l_gain = hwdata[GAIN_W-1:0];
         end else if (st_r.wr_idx >= IDX_R_F1L_GAIN && st_r.wr_idx <= IDX_R_D1R_GAIN) begin
            st_nxt.r_gain[3'(st_r.wr_idx - IDX_R_F1L_GAIN)] = hwdata[GAIN_W-1:0];
         end else if (st_r.wr_idx == IDX_STATUS) begin
            if (hwdata[STAT_SAT_BIT]) begin
               st_nxt.sat_seen = 1'b0;
            end
         end
      end
      // a saturation in the clearing cycle still sticks
      if (sat_now) begin
         st_nxt.sat_seen = 1'b1;
      end
      // address phase; select and gain reads see a write still in its data phase, the status read does not
      st_nxt.wr_pend = addr_ok && hwrite;
      st_nxt.wr_idx = a_idx;
      if (addr_ok && !hwrite) begin
         st_nxt.rdata = '0;
         if (a_idx == IDX_R_SEL) begin
            st_nxt.rdata[NSRC-1:0] = st_nxt.r_sel;
         end else if (a_idx == IDX_O2L_SEL) begin
            st_nxt.rdata[NSRC-1:0] = st_nxt.o2_sel;
         end else if (a_idx == IDX_L_D1R_GAIN) begin
            st_nxt.rdata[GAIN_W-1:0] = st_nxt.l_gain;
         end else if (a_idx >= IDX_R_F1L_GAIN && a_idx <= IDX_R_D1R_GAIN) begin
            st_nxt.rdata[GAIN_W-1:0] = st_nxt.r_gain[3'(a_idx - IDX_R_F1L_GAIN)];
         end else if (a_idx == IDX_STATUS) begin
            st_nxt.rdata[STAT_LEVEL_LSB +: LVL_W] = fifo_level;
            st_nxt.rdata[STAT_SAT_BIT] = st_r.sat_seen;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= ST_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // the fifo absorbs downstream stalls; once full, src_ready drops
   dmx_fifo #(
      .W(OUT_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(hclk),
      .rst_n(hresetn),
      .in_valid(src_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(mix_valid),
      .out_ready(mix_ready),
      .out_data(fifo_out),
      .level(fifo_level)
   );

   assign filter1_right_mix_out = fifo_out[3*SAMPLE_W-1:2*SAMPLE_W];
   assign filt1_left_dai1r_term = fifo_out[2*SAMPLE_W-1:SAMPLE_W];
   assign serial_out2_left_stream = fifo_out[SAMPLE_W-1:0];
   assign hrdata = st_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule // dmx_mixer

`default_nettype wire

// *** tb/dmx_mixer_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module dmx_mixer_props
   import dmx_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // streams
   input wire logic src_valid,
   input wire logic src_ready,
   input wire logic mix_valid,
   input wire logic mix_ready,
   input wire logic [SAMPLE_W-1:0] filter1_right_mix_out,
   input wire logic [SAMPLE_W-1:0] serial_out2_left_stream
);
   wire logic rd_go;
   assign rd_go = hsel && hready && htrans[1] && !hwrite;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence sel_rd;
      rd_go && (haddr[9:2] == IDX_R_SEL || haddr[9:2] == IDX_O2L_SEL);
   endsequence
   sequence gain_rd;
      rd_go && (haddr[9:2] inside {[8'h75:8'h7B], 8'h73});
   endsequence
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   zero_wait_a: assert property (hreadyout == 1'b1)
      else $error("slave inserted a wait state");
   sel_reserved_a: assert property (sel_rd |=> hrdata[31:7] == 25'h0)
      else $error("select read shows bits above the field");
   gain_width_a: assert property (gain_rd |=> hrdata[31:5] == 27'h0)
      else $error("gain read shows bits above the field");
   rdata_hold_a: assert property (!rd_go |=> $stable(hrdata))
      else $error("read data moved without a read");
   out_hold_a: assert property (mix_valid && !mix_ready |=> mix_valid
         && $stable(filter1_right_mix_out) && $stable(serial_out2_left_stream))
      else $error("mixed sample changed before it was taken");
   take_lat_a: assert property (src_valid && src_ready |=> mix_valid)
      else $error("accepted frame did not show at the output");
   idle_empty_a: assert property (!mix_valid && !src_valid |=> !mix_valid)
      else $error("output valid without a frame");
   full_valid_a: assert property (!src_ready |-> mix_valid)
      else $error("input refused while output empty");
endmodule // dmx_mixer_props
bind dmx_mixer dmx_mixer_props u_props (.*);
`default_nettype wire

// *** tb/dmx_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dmx_src_model
   import dmx_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // frame request
   input wire logic req,
   input wire logic [3:0] gap,
   input wire logic [NSRC-1:0][SAMPLE_W-1:0] smp,
   output logic ack,
   // stream side
   output logic valid,
   input wire logic ready,
   output logic [NSRC-1:0][SAMPLE_W-1:0] data
);
   logic [3:0] cnt;
   logic go;
   assign go = req && !valid && !ack && cnt >= gap;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {valid, ack, cnt, data} <= '0;
      end else begin
         ack <= valid && ready;
         if (valid && ready) begin
            valid <= 1'b0;
         end else if (go) begin
            cnt <= 4'h0;
            valid <= 1'b1;
         end else if (req && !valid && !ack) begin
            cnt <= cnt + 4'h1;
         end
         // idle lines toggle so a stale sample never passes for a fresh one
         data <= (valid && !ready) ? data : (go ? smp : ~data);
      end
   end
endmodule // dmx_src_model
`default_nettype wire

// *** tb/dmx_mixer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dmx_mixer_tb;
   import dmx_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, src_valid, src_ready;
   logic mix_valid, mix_ready, req, ack;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [3:0] gap;
   logic [NSRC-1:0][SAMPLE_W-1:0] smp, sdat;
   logic [SAMPLE_W-1:0] o_r, o_l, o_2, f1r, f1l, o2l;
   int err_count = 0, n_compared = 0, cyc = 0;
   assign hready = hreadyout;
   dmx_mixer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .src_valid(src_valid),
      .src_ready(src_ready), .input_filter1_left(sdat[0]), .input_filter1_right(sdat[1]),
      .input_filter2_left(sdat[2]), .input_filter2_right(sdat[3]), .tone_sample(sdat[4]),
      .serial_in1_left(sdat[5]), .serial_in1_right(sdat[6]), .mix_valid(mix_valid),
      .mix_ready(mix_ready), .filter1_right_mix_out(f1r), .filt1_left_dai1r_term(f1l),
      .serial_out2_left_stream(o2l));
   dmx_src_model u_src (.clk(hclk), .rst_n(hresetn), .req(req), .gap(gap), .smp(smp),
      .ack(ack), .valid(src_valid), .ready(src_ready), .data(sdat));
   task end_of_test;
      if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // coefficients are rounded, so allow two counts of slack
   task near(input logic [23:0] got, input real s, input int k);
      real e, g;
      e = s * 10.0 ** ((k * 1.5 - 42.0) / 20.0);
      g = $itor($signed(got));
      check({31'h0, g - e < 2.0 && e - g < 2.0}, 32'h1);
   endtask
   task ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'b00};
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task setsel(input logic [31:0] v);
      ahb(1'b1, IDX_R_SEL, v);
      ahb(1'b1, IDX_O2L_SEL, v);
   endtask
   task send;
      @(posedge hclk);
      req <= 1'b1;
      do @(posedge hclk); while (ack !== 1'b1);
      req <= 1'b0;
   endtask
   task mix;
      send;
      do @(posedge hclk); while (mix_valid !== 1'b1);
      o_r = f1r;
      o_l = f1l;
      o_2 = o2l;
      mix_ready <= 1'b1;
      @(posedge hclk);
      mix_ready <= 1'b0;
   endtask
   task t_regs;
      for (int i = 8'h73; i <= 8'h7C; i++) begin
         ahb(1'b0, 8'(i), 32'h0);
         check(rd, (i == 8'h74 || i == 8'h7C) ? 32'h04 : 32'h1C);
         ahb(1'b1, 8'(i), 32'hFFFFFFFF);
         ahb(1'b0, 8'(i), 32'h0);
         check(rd, (i == 8'h74 || i == 8'h7C) ? 32'h7F : 32'h1F);
         ahb(1'b1, 8'(i), (i == 8'h74 || i == 8'h7C) ? 32'h04 : 32'h1C);
      end
      ahb(1'b1, 8'h10, 32'hFFFFFFFF);
      ahb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
   endtask
   task t_paths;
      int codes [3];
      codes = '{1, 28, 31};
      for (int j = 0; j < NSRC; j++) smp[j] <= 24'((j + 1) * 4096);
      for (int i = 0; i < NSRC; i++) begin
         setsel(32'h80 | (32'h1 << i));
         ahb(1'b1, 8'(8'h75 + i), 32'h0);
         mix;
         near(o_r, (i + 1) * 4096.0, 0);
         check(32'(o_2), 32'(smp[i]));
         check(32'(o_l), 32'(smp[SRC_D1R]));
         ahb(1'b1, 8'(8'h75 + i), 32'h1C);
      end
      setsel(32'h01);
      foreach (codes[k]) begin
         ahb(1'b1, IDX_R_F1L_GAIN, 32'(codes[k]));
         ahb(1'b1, IDX_L_D1R_GAIN, 32'(codes[k]));
         mix;
         near(o_r, 4096.0, codes[k]);
         near(o_l, 7 * 4096.0, codes[k]);
      end
      ahb(1'b1, IDX_R_F1L_GAIN, 32'h1C);
      ahb(1'b1, IDX_L_D1R_GAIN, 32'h1C);
   endtask
   task t_sat;
      setsel(32'h7F);
      for (int v = 0; v < 2; v++) begin
         smp <= {NSRC{(v != 0) ? 24'h800000 : 24'h7FFFFF}};
         mix;
         check(32'(o_r), (v != 0) ? 32'h800000 : 32'h7FFFFF);
         check(32'(o_2), (v != 0) ? 32'h800000 : 32'h7FFFFF);
      end
      // sticky saturation flag, then write one to clear
      ahb(1'b0, IDX_STATUS, 32'h0);
      check(rd, 32'h100);
      ahb(1'b1, IDX_STATUS, 32'h100);
      ahb(1'b0, IDX_STATUS, 32'h0);
      check(rd, 32'h0);
   endtask
   task t_fifo;
      setsel(32'h04);
      gap <= 4'h2;
      for (int n = 0; n < FIFO_DEPTH; n++) begin
         smp[SRC_F2L] <= 24'(n);
         send;
      end
      check(32'(src_ready), 32'h0);
      ahb(1'b0, IDX_STATUS, 32'h0);
      check(rd, 32'(FIFO_DEPTH));
      setsel(32'h01);
      mix_ready <= 1'b1;
      for (int k = 0; k < FIFO_DEPTH;) begin
         @(posedge hclk);
         if (mix_valid === 1'b1) begin
            check(32'(f1r), 32'(k));
            k++;
         end
      end
      mix_ready <= 1'b0;
      @(posedge hclk);
      check(32'(mix_valid), 32'h0);
   endtask
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         end_of_test;
      end
   end
   initial begin
      {hresetn, hsel, hwrite, mix_ready, req} = '0;
      {haddr, hwdata, htrans, gap, smp} = '0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_paths;
      t_sat;
      t_fifo;
      end_of_test;
   end
endmodule // dmx_mixer_tb
`default_nettype wire
